// ---- hdl/oscillator_clock_source_control.sv ----
// Internal oscillator control register, suspend and wake, post-divider, and
// external oscillator pin claim and clock selection.
// Assumes a single-cycle special-function-register bus on sys_clk_in; wake and
// pin inputs arrive asynchronously and are synchronised here.
`timescale 1ns/1ps

`include "osc_ctrl_consts.svh"

// Behaviour
// - Bit 7 enables oscillator, resets to one
// - Bit 6 reads one only when settled
// - Writing suspend halts oscillator until wake
// - Wake on mismatch, timer overflow, transceiver activity
// - Wake on resume, bus reset, device reset
// - Divide-by-four then 8/4/2/1 per field code
// - Bits 4 to 2 read zero, writes ignored
// - Crystal mode claims both crystal terminal pins
// - Other external modes claim terminal B only
// - External clock selectable for system and peripherals
module oscillator_clock_source_control
    import osc_ctrl_pkg::*;
#(
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    // Special-function-register bus
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic [7:0] sfr_wdata_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    output logic      [7:0] sfr_rdata_out,
    output logic            sfr_hit_out,
    // Suspend wake events, asynchronous
    input  wire logic       port_mismatch_in,
    input  wire logic       timer3_overflow_in,
    input  wire logic       usb_activity_in,
    input  wire logic       usb_resume_in,
    input  wire logic       usb_bus_reset_in,
    input  wire logic       usb_reset_in,
    // Internal oscillator
    input  wire logic       int_osc_clk_in,
    output logic            int_osc_run_out,
    output logic      [1:0] int_osc_post_divider_out,
    output logic            int_osc_clk_out,
    // External oscillator drive configuration
    input  wire logic       ext_osc_enable_in,
    input  wire logic       ext_osc_crystal_mode_in,
    input  wire logic       ext_osc_select_system_clock_in,
    input  wire logic       ext_osc_clk_in,
    output logic            crystal_terminal_a_claim_out,
    output logic            crystal_terminal_b_claim_out,
    output logic            system_clock_from_ext_out,
    output logic            periph_ext_clk_out
);

    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

    logic [5:0]       wake_meta_reg;
    logic [5:0]       wake_sync_reg;
    logic [1:0]       osc_meta_reg;
    logic [1:0]       osc_sync_reg;
    logic             enable_reg;
    logic             suspend_reg;
    logic [1:0]       post_div_reg;
    osc_state_t       state_reg;
    logic [CNT_W-1:0] settle_cnt_reg;
    logic [2:0]       div_cnt_reg;
    logic             osc_clk_prev_reg;
    logic             div_out_reg;
    logic             ext_sel_reg;
    logic             ext_clk_reg;
    logic             wake;
    logic             reg_write;
    logic             osc_rise;

    function automatic logic [2:0] div_terminal(input logic [1:0] code);
        case (post_div_t'(code))
            DIV_BY_8: div_terminal = 3'h3;
            DIV_BY_4: div_terminal = 3'h1;
            DIV_BY_2: div_terminal = 3'h0;
            default:  div_terminal = 3'h0;
        endcase
    endfunction

    // Synchronisers for asynchronous inputs
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            wake_meta_reg <= 6'h00;
            wake_sync_reg <= 6'h00;
            osc_meta_reg  <= 2'h0;
            osc_sync_reg  <= 2'h0;
        end else begin
            wake_meta_reg <= {usb_reset_in, usb_bus_reset_in, usb_resume_in,
                              usb_activity_in, timer3_overflow_in, port_mismatch_in};
            wake_sync_reg <= wake_meta_reg;
            osc_meta_reg  <= {ext_osc_clk_in, int_osc_clk_in};
            osc_sync_reg  <= osc_meta_reg;
        end
    end

    assign wake      = |wake_sync_reg;
    assign reg_write = sfr_wr_in && (sfr_addr_in == `INT_OSC_CTRL_ADDR);

    // Control register
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            enable_reg   <= 1'b1;
            suspend_reg  <= 1'b0;
            post_div_reg <= 2'h0;
        end else begin
            if (reg_write) begin
                enable_reg   <= sfr_wdata_in[`BIT_ENABLE];
                post_div_reg <= sfr_wdata_in[`FIELD_DIV_HI:`FIELD_DIV_LO];
            end
            // Wake wins over a suspend request in the same cycle
            if (wake) begin
                suspend_reg <= 1'b0;
            end else if (reg_write && sfr_wdata_in[`BIT_SUSPEND]) begin
                suspend_reg <= 1'b1;
            end
        end
    end

    // Oscillator run state and settle timer
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            state_reg      <= OSC_RUNNING;
            settle_cnt_reg <= '0;
        end else begin
            case (state_reg)
                OSC_OFF: begin
                    if (enable_reg && !suspend_reg) begin
                        state_reg      <= OSC_SETTLING;
                        settle_cnt_reg <= '0;
                    end
                end
                OSC_SETTLING: begin
                    if (!enable_reg) begin
                        state_reg <= OSC_OFF;
                    end else if (suspend_reg) begin
                        state_reg <= OSC_SUSPENDED;
                    end else if (settle_cnt_reg == CNT_W'(SETTLE_CYCLES - 1)) begin
                        state_reg <= OSC_RUNNING;
                    end else begin
                        settle_cnt_reg <= settle_cnt_reg + 1'b1;
                    end
                end
                OSC_RUNNING: begin
                    if (!enable_reg) begin
                        state_reg <= OSC_OFF;
                    end else if (suspend_reg) begin
                        state_reg <= OSC_SUSPENDED;
                    end
                end
                default: begin
                    if (!enable_reg) begin
                        state_reg <= OSC_OFF;
                    end else if (!suspend_reg) begin
                        state_reg      <= OSC_SETTLING;
                        settle_cnt_reg <= '0;
                    end
                end
            endcase
        end
    end

    // Read path
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            sfr_rdata_out <= 8'h00;
            sfr_hit_out   <= 1'b0;
        end else begin
            sfr_hit_out <= 1'b0;
            if (sfr_rd_in && (sfr_addr_in == `INT_OSC_CTRL_ADDR)) begin
                sfr_hit_out   <= 1'b1;
                sfr_rdata_out <= {enable_reg,
                                  state_reg == OSC_RUNNING,
                                  suspend_reg,
                                  3'h0,
                                  post_div_reg};
            end else if (sfr_rd_in) begin
                sfr_rdata_out <= 8'h00;
            end
        end
    end

    // Post-divider on the pre-divided oscillator, sampled on system clock
    assign osc_rise = osc_sync_reg[0] && !osc_clk_prev_reg;

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            osc_clk_prev_reg <= 1'b0;
            div_cnt_reg      <= 3'h0;
            div_out_reg      <= 1'b0;
        end else begin
            osc_clk_prev_reg <= osc_sync_reg[0];
            if (state_reg != OSC_RUNNING) begin
                div_cnt_reg <= 3'h0;
                div_out_reg <= 1'b0;
            end else if (post_div_t'(post_div_reg) == DIV_BY_1) begin
                // Divide by one passes the sampled clock straight through
                div_cnt_reg <= 3'h0;
                div_out_reg <= osc_sync_reg[0];
            end else if (osc_rise) begin
                if (div_cnt_reg >= div_terminal(post_div_reg)) begin
                    div_cnt_reg <= 3'h0;
                    div_out_reg <= ~div_out_reg;
                end else begin
                    div_cnt_reg <= div_cnt_reg + 3'h1;
                end
            end
        end
    end

    // External oscillator pin claim and clock routing
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            crystal_terminal_a_claim_out <= 1'b0;
            crystal_terminal_b_claim_out <= 1'b0;
            ext_sel_reg                  <= 1'b0;
            ext_clk_reg                  <= 1'b0;
        end else begin
            crystal_terminal_a_claim_out <= ext_osc_enable_in && ext_osc_crystal_mode_in;
            crystal_terminal_b_claim_out <= ext_osc_enable_in;
            ext_sel_reg                  <= ext_osc_enable_in && ext_osc_select_system_clock_in;
            ext_clk_reg                  <= ext_osc_enable_in && osc_sync_reg[1];
        end
    end

    assign int_osc_run_out           = (state_reg == OSC_SETTLING) || (state_reg == OSC_RUNNING);
    assign int_osc_post_divider_out  = post_div_reg;
    assign int_osc_clk_out           = div_out_reg;
    assign system_clock_from_ext_out = ext_sel_reg;
    assign periph_ext_clk_out        = ext_clk_reg;

endmodule

// ---- hdl/osc_ctrl_consts.svh ----
// Offsets, field positions, reset values and timing counts of the oscillator control block.
// Included by the package and the design module; definitions only.
`ifndef OSC_CTRL_CONSTS_SVH
`define OSC_CTRL_CONSTS_SVH

`define INT_OSC_CTRL_ADDR     8'hb2
`define INT_OSC_CTRL_RESET    8'h80
`define BIT_ENABLE            7
`define BIT_READY             6
`define BIT_SUSPEND           5
`define FIELD_DIV_HI          1
`define FIELD_DIV_LO          0
`define SETTLE_TIME_NS        1000
`define CLK_PERIOD_NS         50
`define SETTLE_CYCLES         ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRESCALE_DIV          4

`endif

// ---- hdl/osc_ctrl_pkg.sv ----
// Types shared by the oscillator control block.
// Assumes the constants header sits beside it.
package osc_ctrl_pkg;
    `include "osc_ctrl_consts.svh"

    typedef enum logic [1:0] {
        OSC_OFF,
        OSC_SETTLING,
        OSC_RUNNING,
        OSC_SUSPENDED
    } osc_state_t;

    typedef enum logic [1:0] {
        DIV_BY_8,
        DIV_BY_4,
        DIV_BY_2,
        DIV_BY_1
    } post_div_t;
endpackage

// ---- verification/osc_partner.sv ----
// Free-running clock sources on the far side of the oscillator block.
// Internal source arrives already divided by four; external one is a CMOS clock.
`timescale 1ns/1ps
module osc_partner #(
    parameter int INT_HALF_NS = 200,
    parameter int EXT_HALF_NS = 150
) (
    output logic int_clk_out,
    output logic ext_clk_out
);
    // Pins are taken as skipped by the crossbar and set as inputs
    initial begin
        int_clk_out = 1'b0;
        forever #(INT_HALF_NS) int_clk_out = ~int_clk_out;
    end
    initial begin
        ext_clk_out = 1'b1;
        forever #(EXT_HALF_NS) ext_clk_out = ~ext_clk_out;
    end
endmodule

// ---- verification/oscillator_clock_source_control_monitor.sv ----
// Port checker for the oscillator control block.
// Bound to the design from the bench top file.
`timescale 1ns/1ps
module oscillator_clock_source_control_monitor (
    input wire logic       sys_clk_in, rstn_in, sfr_wr_in, sfr_rd_in, sfr_hit_out,
    input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out,
    input wire logic [1:0] int_osc_post_divider_out,
    input wire logic       int_osc_run_out, int_osc_clk_out, ext_osc_enable_in,
    input wire logic       ext_osc_crystal_mode_in, ext_osc_select_system_clock_in,
    input wire logic       crystal_terminal_a_claim_out, crystal_terminal_b_claim_out,
    input wire logic       system_clock_from_ext_out, periph_ext_clk_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    wire logic rd_hit = sfr_rd_in && sfr_addr_in == 8'hb2;
    wire logic wr_hit = sfr_wr_in && sfr_addr_in == 8'hb2;
    a_read_hit: assert property (rd_hit |=> sfr_hit_out) else $error("no read hit");
    a_unused_zero: assert property (rd_hit |=> sfr_rdata_out[4:2] == 3'h0)
        else $error("unused bits set");
    a_ready_needs_run: assert property (rd_hit && !int_osc_run_out |=> !sfr_rdata_out[6])
        else $error("ready while stopped");
    a_disable_stops: assert property (wr_hit && !sfr_wdata_in[7] |-> ##2 !int_osc_run_out)
        else $error("oscillator still on");
    a_div_follows: assert property (wr_hit |=>
        int_osc_post_divider_out == $past(sfr_wdata_in[1:0])) else $error("divider wrong");
    a_idle_no_clk: assert property (!int_osc_run_out |=> !int_osc_clk_out)
        else $error("clock while stopped");
    a_claim_a: assert property (1'b1 |=> crystal_terminal_a_claim_out ==
        $past(ext_osc_enable_in && ext_osc_crystal_mode_in)) else $error("claim a wrong");
    a_claim_b: assert property (1'b1 |=>
        crystal_terminal_b_claim_out == $past(ext_osc_enable_in)) else $error("claim b wrong");
    a_system_clock_sel: assert property (1'b1 |=> system_clock_from_ext_out ==
        $past(ext_osc_enable_in && ext_osc_select_system_clock_in)) else $error("select wrong");
    a_periph_gated: assert property (!ext_osc_enable_in |=> !periph_ext_clk_out)
        else $error("peripheral clock leak");
endmodule

// ---- verification/oscillator_clock_source_control_bench.sv ----
// Self-checking bench for the oscillator control block.
// Inputs change on the falling edge; the port checker is bound below.
`timescale 1ns/1ps
module oscillator_clock_source_control_bench;
    logic       clk, rstn, wr, rd, hit, run, int_clk, ext_clk, clk_o;
    logic       claim_a, claim_b, sys_ext, per_clk;
    logic [7:0] addr, wdata, rdata;
    logic [5:0] wake;
    logic [2:0] cfg;
    logic [1:0] div;
    int         failures, checks_done;
    osc_partner part (.int_clk_out(int_clk), .ext_clk_out(ext_clk));
    oscillator_clock_source_control #(.SETTLE_CYCLES(2)) dut (
        .sys_clk_in(clk), .rstn_in(rstn), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
        .port_mismatch_in(wake[0]), .timer3_overflow_in(wake[1]), .usb_activity_in(wake[2]),
        .usb_resume_in(wake[3]), .usb_bus_reset_in(wake[4]), .usb_reset_in(wake[5]),
        .int_osc_clk_in(int_clk), .int_osc_run_out(run), .int_osc_post_divider_out(div),
        .int_osc_clk_out(clk_o), .ext_osc_enable_in(cfg[2]), .ext_osc_crystal_mode_in(cfg[1]),
        .ext_osc_select_system_clock_in(cfg[0]), .ext_osc_clk_in(ext_clk),
        .crystal_terminal_a_claim_out(claim_a), .crystal_terminal_b_claim_out(claim_b),
        .system_clock_from_ext_out(sys_ext), .periph_ext_clk_out(per_clk));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("hit", {7'h0, hit}, {7'h0, a == 8'hb2});
        chk("read", rdata, e);
    endtask
    task automatic t_fields();
        rd_reg(8'hb2, 8'hc0);
        rd_reg(8'h55, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'hb2, 8'h9c | 8'(i));
            rd_reg(8'hb2, 8'hc0 | 8'(i));
            chk("div", {6'h0, div}, 8'(i));
        end
    endtask
    task automatic t_divider();
        int   cnt;
        logic prev;
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'hb2, 8'h80 | 8'(i));
            cyc(80);
            cnt = 0;
            prev = clk_o;
            repeat (256) begin
                @(negedge clk);
                cnt += int'(clk_o != prev);
                prev = clk_o;
            end
            chk("div_clk", 8'(cnt), 8'(8 << i));
        end
    endtask
    task automatic t_enable();
        wr_reg(8'hb2, 8'h00);
        cyc(3);
        chk("run", {7'h0, run}, 8'h00);
        rd_reg(8'hb2, 8'h00);
        wr_reg(8'hb2, 8'h80);
        rd_reg(8'hb2, 8'h80);
        cyc(6);
        rd_reg(8'hb2, 8'hc0);
    endtask
    task automatic t_suspend();
        for (int i = 0; i < 6; i++) begin
            wr_reg(8'hb2, 8'ha0);
            cyc(3);
            chk("run", {7'h0, run}, 8'h00);
            rd_reg(8'hb2, 8'ha0);
            wake[i] = 1'b1;
            cyc(5);
            wake[i] = 1'b0;
            cyc(6);
            rd_reg(8'hb2, 8'hc0);
        end
    endtask
    task automatic t_reset();
        wr_reg(8'hb2, 8'ha3);
        cyc(3);
        rd_reg(8'hb2, 8'ha3);
        rstn = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        rd_reg(8'hb2, 8'hc0);
        chk("div", {6'h0, div}, 8'h00);
    endtask
    task automatic t_external();
        int cnt;
        for (int c = 0; c < 8; c++) begin
            cfg = 3'(c);
            cyc(3);
            cnt = 0;
            repeat (24) begin
                @(negedge clk);
                cnt += int'(per_clk);
            end
            chk("claim_a", {7'h0, claim_a}, {7'h0, cfg[2] & cfg[1]});
            chk("claim_b", {7'h0, claim_b}, {7'h0, cfg[2]});
            chk("sys_ext", {7'h0, sys_ext}, {7'h0, cfg[2] & cfg[0]});
            chk("periph", {7'h0, cnt > 0}, {7'h0, cfg[2]});
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {failures, checks_done} = '0;
        {rstn, wr, rd, addr, wdata, wake, cfg} = '0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        t_fields();
        t_divider();
        t_enable();
        t_suspend();
        t_reset();
        t_external();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule
bind oscillator_clock_source_control oscillator_clock_source_control_monitor mon (
    .sys_clk_in, .rstn_in, .sfr_wr_in, .sfr_rd_in, .sfr_hit_out, .sfr_addr_in,
    .sfr_wdata_in, .sfr_rdata_out, .int_osc_post_divider_out, .int_osc_run_out,
    .int_osc_clk_out, .ext_osc_enable_in, .ext_osc_crystal_mode_in,
    .ext_osc_select_system_clock_in, .crystal_terminal_a_claim_out,
    .crystal_terminal_b_claim_out, .system_clock_from_ext_out, .periph_ext_clk_out);
